// ---- logic/ircg_carrier.sv ----
/*
 * Infrared carrier generator: count registers, output latch, polarity,
 * 6-bit high/low time counter and infrared pin selection.
 * Assumes a modulator outside that supplies its output level and a
 * one-cycle pulse at each mark expiry, and a plain register port master.
 * Assumes software loads nonzero counts before it sets the enable bit.
 */
// Chosen here: the strobed register port.
//
// Overview of operation
// - carrier period is high count plus low count
// - second count pair kept for FSK
// - generator runs only when enabled, not baseband
// - 6-bit up counter, match clears, swaps compare
// - high match drives low, low match high
// - frequency is input clock over count sum
// - half-rate prescale halves generator input clock
// - primary high holds latch, polarity, count
// - primary low holds latch, zero, count
// - secondary registers hold count, upper bits zero
// - time mode uses primary pair only
// - FSK mode alternates pairs under modulator
// - primary high write updates latch and fields together
// - disabled block drives pin from latch
// - polarity bit inverts pin, resets zero
// - bit 7 of primaries reads latch
// - high write loads latch, low write later
// - output latch cleared by reset
// - baseband holds carrier high
// - FSK swaps pairs at each mark expiry
// - enabled block drives pin from modulator

`timescale 1ns/1ps
`include "ircg_params.svh"

module ircg_carrier
   import ircg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [`IRCG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // modulator side
   input wire logic mark_expired,
   input wire logic modulator_out,
   output logic carrier_out,
   // infrared output pin
   output logic infrared_output_pin
);

   // decoded write strobes
   logic wr_pri_high;
   logic wr_pri_low;
   logic wr_sec_high;
   logic wr_sec_low;
   logic wr_control;

   // register contents
   ircg_count_t primary_high_count_q;
   ircg_count_t primary_low_count_q;
   ircg_count_t secondary_high_count_q;
   ircg_count_t secondary_low_count_q;
   logic output_polarity_q;
   logic latch_q;
   logic latch_pend_q;
   logic latch_pend_val_q;
   logic modulator_carrier_enable_q;
   logic fsk_mode_q;
   logic baseband_select_q;
   logic half_rate_prescale_q;

   // generator state
   ircg_count_t count_q;
   ircg_count_t count_d;
   ircg_count_t compare_val;
   ircg_phase_e phase_q;
   logic use_secondary_q;
   logic prescale_q;
   logic run;
   logic tick;
   logic match;

   // address match used by every strobe decode
   function automatic logic hit(input logic [`IRCG_ADDR_W-1:0] a,
                                input logic [`IRCG_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // choose the count of the active pair for the active phase
   function automatic ircg_count_t pick(input logic sec, input ircg_phase_e ph,
                                        input ircg_count_t pri_hi, input ircg_count_t pri_lo,
                                        input ircg_count_t sec_hi, input ircg_count_t sec_lo);
      if (sec) begin
         pick = (ph == IRCG_PH_HIGH) ? sec_hi : sec_lo;
      end else begin
         pick = (ph == IRCG_PH_HIGH) ? pri_hi : pri_lo;
      end
   endfunction : pick

   // write strobe decode
   // unmapped addresses fall through and are ignored
   assign wr_pri_high = reg_wr && hit(reg_addr, `IRCG_OFS_PRI_HIGH);
   assign wr_pri_low = reg_wr && hit(reg_addr, `IRCG_OFS_PRI_LOW);
   assign wr_sec_high = reg_wr && hit(reg_addr, `IRCG_OFS_SEC_HIGH);
   assign wr_sec_low = reg_wr && hit(reg_addr, `IRCG_OFS_SEC_LOW);
   assign wr_control = reg_wr && hit(reg_addr, `IRCG_OFS_CONTROL);

   // primary high count: data only, left untouched by reset
   // a zero count never matches before the counter wraps through 64
   always_ff @(posedge clk) begin
      if (wr_pri_high) begin
         primary_high_count_q <= reg_wdata[`IRCG_COUNT_MSB:0];
      end
   end

   // primary low count, loaded by the same write as the delayed latch
   always_ff @(posedge clk) begin
      if (wr_pri_low) begin
         primary_low_count_q <= reg_wdata[`IRCG_COUNT_MSB:0];
      end
   end

   // secondary high count, only compared in FSK mode
   always_ff @(posedge clk) begin
      if (wr_sec_high) begin
         secondary_high_count_q <= reg_wdata[`IRCG_COUNT_MSB:0];
      end
   end

   // secondary low count, only compared in FSK mode
   always_ff @(posedge clk) begin
      if (wr_sec_low) begin
         secondary_low_count_q <= reg_wdata[`IRCG_COUNT_MSB:0];
      end
   end

   // polarity bit, written only through the primary high register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         output_polarity_q <= `IRCG_RST_POLARITY;
      end else if (wr_pri_high) begin
         output_polarity_q <= reg_wdata[`IRCG_BIT_POLARITY];
      end
   end

   // low-register write is held one clock before reaching the latch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latch_pend_q <= 1'b0;
      end else begin
         latch_pend_q <= wr_pri_low;
      end
   end

   // bit 7 of that write, carried beside the pending flag
   always_ff @(posedge clk) begin
      latch_pend_val_q <= reg_wdata[`IRCG_BIT_LATCH];
   end

   // output latch: high write lands at once, low write one cycle on
   // a high write in the same cycle as a pending low write wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latch_q <= `IRCG_RST_LATCH;
      end else if (wr_pri_high) begin
         latch_q <= reg_wdata[`IRCG_BIT_LATCH];
      end else if (latch_pend_q) begin
         latch_q <= latch_pend_val_q;
      end
   end

   // reset image of the control byte, taken apart bit by bit below
   localparam logic [7:0] rst_control = `IRCG_RST_CONTROL;

   // enable bit: runs the generator and hands the pin to the modulator
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         modulator_carrier_enable_q <= rst_control[`IRCG_BIT_ENABLE];
      end else if (wr_control) begin
         modulator_carrier_enable_q <= reg_wdata[`IRCG_BIT_ENABLE];
      end
   end

   // mode bit: FSK lets the modulator swap count pairs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fsk_mode_q <= rst_control[`IRCG_BIT_FSK];
      end else if (wr_control) begin
         fsk_mode_q <= reg_wdata[`IRCG_BIT_FSK];
      end
   end

   // baseband bit: stops the generator and holds the carrier high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         baseband_select_q <= rst_control[`IRCG_BIT_BASEBAND];
      end else if (wr_control) begin
         baseband_select_q <= reg_wdata[`IRCG_BIT_BASEBAND];
      end
   end

   // half-rate bit is not double buffered; a change mid burst stretches a phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         half_rate_prescale_q <= rst_control[`IRCG_BIT_HALF_RATE];
      end else if (wr_control) begin
         half_rate_prescale_q <= reg_wdata[`IRCG_BIT_HALF_RATE];
      end
   end

   // generator clocking conditions
   // with half rate every other clock is a tick, so both phases double
   assign run = modulator_carrier_enable_q && !baseband_select_q;
   assign tick = run && (!half_rate_prescale_q || prescale_q);

   // divide-by-two prescaler, restarts whenever the generator stops
   // a fresh start gives the first phase its full length
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prescale_q <= 1'b0;
      end else if (!run) begin
         prescale_q <= 1'b0;
      end else begin
         prescale_q <= !prescale_q;
      end
   end

   // compare value and increment
   // the compare sees the incremented value, so a count of n takes n ticks
   assign compare_val = pick(use_secondary_q, phase_q, primary_high_count_q,
                             primary_low_count_q, secondary_high_count_q,
                             secondary_low_count_q);
   assign count_d = count_q + 6'h01;
   assign match = (count_d == compare_val);

   // 6-bit up counter, cleared on every match
   // stopping clears it so the next start counts a whole high phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q <= `IRCG_RST_COUNT;
      end else if (!run) begin
         count_q <= `IRCG_RST_COUNT;
      end else if (tick) begin
         count_q <= match ? `IRCG_RST_COUNT : count_d;
      end
   end

   // phase machine: high compare then low compare, repeating
   // a single bit, so the gray order holds trivially
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_q <= IRCG_PH_HIGH;
      end else if (!run) begin
         phase_q <= IRCG_PH_HIGH;
      end else if (tick && match) begin
         case (phase_q)
            IRCG_PH_HIGH: begin
               phase_q <= IRCG_PH_LOW;
            end
            IRCG_PH_LOW: begin
               phase_q <= IRCG_PH_HIGH;
            end
            default: begin
               phase_q <= IRCG_PH_HIGH;
            end
         endcase
      end
   end

   // carrier level to the modulator
   // high while stopped so the modulator sees a clean first edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         carrier_out <= 1'b1;
      end else if (!run) begin
         carrier_out <= 1'b1;
      end else if (tick && match) begin
         carrier_out <= (phase_q == IRCG_PH_LOW);
      end
   end

   // pair select: primary in time mode, swapped per mark expiry in FSK
   // the swap acts on the very next compare; an expiry in mid phase can
   // leave the count above the new value, stretching that phase by a wrap
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         use_secondary_q <= 1'b0;
      end else if (!run || !fsk_mode_q) begin
         use_secondary_q <= 1'b0;
      end else if (mark_expired) begin
         use_secondary_q <= !use_secondary_q;
      end
   end

   // pin: latch when disabled, modulator when enabled, then polarity
   // polarity acts on both sources, so the idle pin level follows it too
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         infrared_output_pin <= `IRCG_RST_LATCH ^ `IRCG_RST_POLARITY;
      end else if (modulator_carrier_enable_q) begin
         infrared_output_pin <= modulator_out ^ output_polarity_q;
      end else begin
         infrared_output_pin <= latch_q ^ output_polarity_q;
      end
   end

   // read data, valid in the cycle after the strobe only
   // zero outside that cycle keeps stale data off the bus
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            `IRCG_OFS_PRI_HIGH: begin
               reg_rdata <= {latch_q, output_polarity_q, primary_high_count_q};
            end
            `IRCG_OFS_PRI_LOW: begin
               reg_rdata <= {latch_q, 1'b0, primary_low_count_q};
            end
            `IRCG_OFS_SEC_HIGH: begin
               reg_rdata <= {2'b00, secondary_high_count_q};
            end
            `IRCG_OFS_SEC_LOW: begin
               reg_rdata <= {2'b00, secondary_low_count_q};
            end
            `IRCG_OFS_CONTROL: begin
               reg_rdata <= {1'b0, half_rate_prescale_q, carrier_out, use_secondary_q,
                             1'b0, baseband_select_q, fsk_mode_q,
                             modulator_carrier_enable_q};
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end

endmodule : ircg_carrier

// ---- logic/ircg_params.svh ----
/*
 * Offsets, field positions and reset values of the infrared carrier generator.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef IRCG_PARAMS_SVH
`define IRCG_PARAMS_SVH

// register offsets (byte wide registers)
`define IRCG_ADDR_W 8
`define IRCG_OFS_PRI_HIGH 8'h10
`define IRCG_OFS_PRI_LOW 8'h11
`define IRCG_OFS_SEC_HIGH 8'h12
`define IRCG_OFS_SEC_LOW 8'h13
`define IRCG_OFS_CONTROL 8'h14

// field positions
`define IRCG_BIT_LATCH 7
`define IRCG_BIT_POLARITY 6
`define IRCG_COUNT_MSB 5
`define IRCG_COUNT_W 6
`define IRCG_BIT_ENABLE 0
`define IRCG_BIT_FSK 1
`define IRCG_BIT_BASEBAND 2
`define IRCG_BIT_SEC_ACTIVE 4
`define IRCG_BIT_CARRIER 5
`define IRCG_BIT_HALF_RATE 6

// reset values
`define IRCG_RST_LATCH 1'b0
`define IRCG_RST_POLARITY 1'b0
`define IRCG_RST_CONTROL 8'h00
`define IRCG_RST_COUNT 6'h00

`endif

// ---- logic/ircg_pkg.sv ----
/*
 * Types shared by the infrared carrier generator.
 * Assumes ircg_params.svh is on the include path.
 */
`include "ircg_params.svh"

package ircg_pkg;
   // compare phase: which count of the pair is being matched
   typedef enum logic {
      IRCG_PH_HIGH = 1'b0,
      IRCG_PH_LOW = 1'b1
   } ircg_phase_e;

   typedef logic [`IRCG_COUNT_W-1:0] ircg_count_t;
   typedef logic [7:0] ircg_byte_t;
endpackage : ircg_pkg

// ---- sim/ircg_carrier_properties.sv ----
/* port assertions for the infrared carrier generator
   assumes it is bound to ircg_carrier, one clock, reset synchronous */
`timescale 1ns/1ps
`include "ircg_params.svh"
module ircg_carrier_properties
   import ircg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [`IRCG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // modulator side and pin
   input wire logic mark_expired,
   input wire logic modulator_out,
   input wire logic carrier_out,
   input wire logic infrared_output_pin
);
   logic en_q, bband_q, pol_q;
   wire logic run = en_q && !bband_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow of enable, baseband and polarity
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_q <= 1'b0;
         bband_q <= 1'b0;
         pol_q <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h14) begin
         en_q <= reg_wdata[0];
         bband_q <= reg_wdata[2];
      end else if (reg_wr && reg_addr == 8'h10) begin
         pol_q <= reg_wdata[6];
      end
   end
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   AST_CAR_IDLE: assert property (!run && !$past(run) |-> carrier_out)
      else $error("carrier not held high");
   AST_LATCH_HI: assert property (reg_wr && reg_addr == 8'h10 && !en_q |-> ##2
      infrared_output_pin == ($past(reg_wdata[7], 2) ^ $past(reg_wdata[6], 2)))
      else $error("pin after high write");
   AST_LATCH_LO: assert property (reg_wr && reg_addr == 8'h11 && !en_q
      ##1 !(reg_wr && reg_addr == 8'h10) ##1 !en_q
      |-> ##1 infrared_output_pin == ($past(reg_wdata[7], 3) ^ $past(pol_q)))
      else $error("pin after low write");
   AST_SEC_ZERO: assert property ($past(reg_rd) && $past(reg_addr[7:1]) == 7'h09
      |-> reg_rdata[7:6] == 2'b00) else $error("secondary upper bits");
   AST_PLO_B6: assert property ($past(reg_rd) && $past(reg_addr) == 8'h11
      |-> !reg_rdata[6]) else $error("low bit 6 set");
   AST_LATCH_RD: assert property ($past(reg_rd) && $past(reg_addr[7:1]) == 7'h08
      && !en_q && !$past(en_q) |-> (reg_rdata[7] ^ pol_q) == infrared_output_pin)
      else $error("latch readback");
   AST_MOD_PIN: assert property (en_q && $past(en_q)
      |-> infrared_output_pin == ($past(modulator_out) ^ $past(pol_q)))
      else $error("pin not from modulator");
endmodule : ircg_carrier_properties

// ---- sim/ircg_modulator_model.sv ----
/* behavioural modulator facing the carrier generator
   assumes the bench asks for each mark expiry with a one-cycle request */
`timescale 1ns/1ps
module ircg_modulator_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench control
   input wire logic mark_req,
   // generator side
   input wire logic carrier_out,
   output logic mark_expired,
   output logic modulator_out
);
   // mark expiry pulse and carrier, each registered and passed on one clock later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mark_expired <= 1'b0;
         modulator_out <= 1'b0;
      end else begin
         mark_expired <= mark_req;
         modulator_out <= carrier_out;
      end
   end
endmodule : ircg_modulator_model

// ---- sim/tb_top.sv ----
/* self-checking bench for the infrared carrier generator
   assumes the design package, header and the two sim models compiled first */
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mreq = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic mark_expired, modulator_out, carrier_out, pin;
   int num_errors = 0, n_checks = 0;
   // free running clock
   always #5 clk = ~clk;
   ircg_carrier ircg_carrier_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mark_expired(mark_expired), .modulator_out(modulator_out),
      .carrier_out(carrier_out), .infrared_output_pin(pin));
   ircg_modulator_model ircg_modulator_model_i (.clk(clk), .rst_n(rst_n), .mark_req(mreq),
      .carrier_out(carrier_out), .mark_expired(mark_expired), .modulator_out(modulator_out));
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata & m, exp);
   endtask : rd
   // a bounded wait that ran out counts a mismatch and ends the run
   task hang;
      num_errors++;
      $display("mismatch at %0t: carrier hang", $time);
      tally_and_finish();
   endtask : hang
   // bounded wait for a carrier level
   task wait_lvl(input logic v);
      int n;
      for (n = 0; n < 300 && carrier_out !== v; n++) @(negedge clk);
      if (n == 300) hang();
   endtask : wait_lvl
   // low then high phase length in clocks
   task meas(input logic [7:0] lo, input logic [7:0] hi);
      int n;
      @(negedge clk);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      for (n = 0; n < 200 && carrier_out === 1'b0; n++) @(negedge clk);
      if (n == 200) hang();
      chk(8'(n), lo);
      for (n = 0; n < 200 && carrier_out === 1'b1; n++) @(negedge clk);
      if (n == 200) hang();
      chk(8'(n), hi);
   endtask : meas
   task mark;
      @(posedge clk);
      mreq <= 1'b1;
      @(posedge clk);
      mreq <= 1'b0;
   endtask : mark
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h10, 8'h00, 8'hc0);
      rd(8'h14, 8'h20, 8'hff);
      chk({7'h00, pin}, 8'h00);
      wr(8'h10, 8'hc5);
      rd(8'h10, 8'hc5, 8'hff);
      chk({7'h00, pin}, 8'h00);
      wr(8'h11, 8'hff);
      rd(8'h11, 8'hbf, 8'hff);
      wr(8'h11, 8'h03);
      rd(8'h10, 8'h45, 8'hff);
      wr(8'h10, 8'h82);
      rd(8'h10, 8'h82, 8'hff);
      chk({7'h00, pin}, 8'h01);
      wr(8'h10, 8'h02);
      wr(8'h12, 8'hc5);
      rd(8'h12, 8'h05, 8'hff);
      wr(8'h13, 8'h41);
      rd(8'h13, 8'h01, 8'hff);
      rd(8'h20, 8'h00, 8'hff);
      wr(8'h14, 8'h01);
      meas(8'h03, 8'h02);
      wr(8'h14, 8'h00);
      wr(8'h14, 8'h41);
      meas(8'h06, 8'h04);
      wr(8'h14, 8'h05);
      repeat (20) @(negedge clk);
      chk({7'h00, carrier_out}, 8'h01);
      wr(8'h14, 8'h03);
      meas(8'h03, 8'h02);
      mark();
      meas(8'h01, 8'h05);
      rd(8'h14, 8'h13, 8'hdf);
      mark();
      meas(8'h03, 8'h02);
      wr(8'h14, 8'h00);
      tally_and_finish();
   end
endmodule : tb_top
bind ircg_carrier ircg_carrier_properties ircg_carrier_properties_i (.clk(clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .mark_expired(mark_expired), .modulator_out(modulator_out),
   .carrier_out(carrier_out), .infrared_output_pin(infrared_output_pin));
